// >>> inc/wtc_pkg.sv
package wtc_pkg;
   // fixed upper nibble of the slave address byte
   localparam logic [3:0] ADDR_NIBBLE = 4'h5;
   // instruction upper nibbles and stepping prefix
   localparam logic [3:0] OP_GSTORE_NIB = 4'h8;
   localparam logic [3:0] OP_STORE_NIB = 4'he;
   localparam logic [3:0] OP_RECALL_NIB = 4'hd;
   localparam logic [5:0] OP_STEP_PFX = 6'h08;
   // field positions inside the instruction byte
   localparam int SLOT_SEL_LSB = 2;
   localparam int POT_SEL_LSB = 0;
   // wiper range and reset value
   localparam logic [5:0] WIPER_MAX = 6'h3f;
   localparam logic [5:0] WIPER_MIN = 6'h00;
   localparam logic [5:0] WIPER_RST = 6'h00;
   // bit counter marks inside a byte and an acknowledge slot
   localparam logic [3:0] BYTE_DONE = 4'h8;
   localparam logic [3:0] ACK_SEEN = 4'h1;
   // all-pots mask for the global store
   localparam logic [3:0] ALL_POTS = 4'hf;

   // decoded command
   typedef enum logic [2:0] {
      OP_NONE, OP_GSTORE, OP_STORE, OP_RECALL, OP_STEP
   } wtc_op_t;

   // frame state
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_INSTR, ST_ACK_INSTR,
      ST_WAIT_STOP, ST_STEP
   } wtc_state_t;
endpackage : wtc_pkg

// >>> inc/wtc_line_if.sv
// bus events from the pin front end to the frame decoder
interface wtc_line_if;
   logic start;          // start condition seen, one cycle
   logic stop;           // stop condition seen, one cycle
   logic scl_rise;       // clock rising edge, one cycle
   logic scl_fall;       // clock falling edge, one cycle
   logic sda_lvl;        // synchronised data level
   logic [3:0] chip_sel; // synchronised strap inputs

   modport front (output start, stop, scl_rise, scl_fall, sda_lvl,
                  chip_sel);
   modport core (input start, stop, scl_rise, scl_fall, sda_lvl,
                 chip_sel);
endinterface : wtc_line_if

// >>> hdl/wtc_pin_front.sv
module wtc_pin_front (
   input wire logic clk_in,           // system clock
   input wire logic resetn_in,        // async reset, active low
   input wire logic scl_in,           // bus clock pin
   input wire logic sda_in,           // bus data pin level
   input wire logic [3:0] chip_select_in, // address straps
   wtc_line_if.front ev               // events toward the decoder
);
   // all state of the front end
   typedef struct packed {
      logic scl_s1;     // first synchroniser stage
      logic scl_s2;     // second synchroniser stage
      logic scl_d;      // delayed copy for edge detect
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      logic [3:0] cs_s1;
      logic [3:0] cs_s2;
   } wtc_front_t;

   wtc_front_t front_q;
   wtc_front_t front_d;

   ////////////////////////////////////////////////////////////////////////
   // next state: the second stages and the delayed copies feed the detectors
   always_comb begin
      front_d = front_q;
      front_d.scl_s1 = scl_in;
      front_d.scl_s2 = front_q.scl_s1;
      front_d.scl_d = front_q.scl_s2;
      front_d.sda_s1 = sda_in;
      front_d.sda_s2 = front_q.sda_s1;
      front_d.sda_d = front_q.sda_s2;
      front_d.cs_s1 = chip_select_in;
      front_d.cs_s2 = front_q.cs_s1;
   end

   // state register; lines idle high
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         front_q <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
                      sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
                      cs_s1: 4'h0, cs_s2: 4'h0};
      end else begin
         front_q <= front_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // edge and condition detect, all from the second stage onward
   assign ev.scl_rise = front_q.scl_s2 & ~front_q.scl_d;
   assign ev.scl_fall = ~front_q.scl_s2 & front_q.scl_d;
   // data moving while the clock stays high marks start or stop
   assign ev.start = front_q.scl_s2 & front_q.scl_d &
                     ~front_q.sda_s2 & front_q.sda_d;
   assign ev.stop = front_q.scl_s2 & front_q.scl_d &
                    front_q.sda_s2 & ~front_q.sda_d;
   assign ev.sda_lvl = front_q.sda_s2;
   assign ev.chip_sel = front_q.cs_s2;
endmodule : wtc_pin_front

// >>> hdl/wtc_cmd_decode.sv
module wtc_cmd_decode (
   input wire logic clk_in,             // 100 MHz system clock
   input wire logic resetn_in,          // async reset, active low
   input wire logic scl_in,             // bus clock pin
   input wire logic sda_in,             // bus data pin input
   output logic sda_out,                // bus data pin output value
   output logic sda_oe_out,             // high while pulling data low
   input wire logic [3:0] chip_select_in, // strapped address bits
   output logic [23:0] wiper_pos_out,   // four 6-bit wiper positions
   output logic [1:0] nv_rd_pot_out,    // setting store read pot
   output logic [1:0] nv_rd_slot_out,   // setting store read slot
   input wire logic [5:0] nv_rdata_in,  // setting store read data
   output logic nv_wr_start_out,        // one-cycle write start pulse
   output logic [3:0] nv_wr_pot_mask_out, // pots to write
   output logic [1:0] nv_wr_slot_out,   // slot to write
   output logic [23:0] nv_wr_data_out,  // wiper snapshot to write
   output logic step_active_out         // stepping run in progress
);
   // all state of the decoder
   typedef struct packed {
      wtc_pkg::wtc_state_t state; // frame position
      logic [3:0] cnt;            // bits seen in this byte or ack
      logic [7:0] shift;          // incoming byte
      wtc_pkg::wtc_op_t op;       // accepted command
      logic [1:0] pot;            // selected pot
      logic [1:0] slot;           // selected slot
      logic pend;                 // store waits for stop
      logic [3:0][5:0] wiper;     // wiper position registers
      logic oe;                   // data pin pulled low
      logic wr_start;             // write start pulse
      logic [3:0] wr_mask;
      logic [1:0] wr_slot;
      logic [23:0] wr_data;
      logic step;                 // stepping run flag
   } wtc_core_t;

   wtc_core_t core_q;
   wtc_core_t core_d;

   wtc_line_if line ();

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and condition detect
   wtc_pin_front u_front (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .chip_select_in(chip_select_in),
      .ev(line)
   );

   ////////////////////////////////////////////////////////////////////////
   // instruction byte to command; unlisted codes give no acknowledge
   function automatic wtc_pkg::wtc_op_t op_decode(input logic [7:0] b);
      wtc_pkg::wtc_op_t r;
      r = wtc_pkg::OP_NONE;
      if (b[7:4] == wtc_pkg::OP_GSTORE_NIB && b[1:0] == 2'h0) begin
         r = wtc_pkg::OP_GSTORE;
      end else if (b[7:4] == wtc_pkg::OP_STORE_NIB) begin
         r = wtc_pkg::OP_STORE;
      end else if (b[7:4] == wtc_pkg::OP_RECALL_NIB) begin
         r = wtc_pkg::OP_RECALL;
      end else if (b[7:2] == wtc_pkg::OP_STEP_PFX) begin
         r = wtc_pkg::OP_STEP;
      end
      return r;
   endfunction : op_decode

   // one segment step, held at the ends of the range
   function automatic logic [5:0] step_wiper(input logic [5:0] w,
                                             input logic up);
      logic [5:0] r;
      r = w;
      if (up && w != wtc_pkg::WIPER_MAX) begin
         r = w + 6'h01;
      end else if (!up && w != wtc_pkg::WIPER_MIN) begin
         r = w - 6'h01;
      end
      return r;
   endfunction : step_wiper

   ////////////////////////////////////////////////////////////////////////
   // frame sequencer
   always_comb begin
      core_d = core_q;
      core_d.wr_start = 1'b0; // pulse lasts one cycle
      if (line.start) begin
         // a start aborts any frame; a store not yet stopped is lost
         core_d.state = wtc_pkg::ST_ADDR;
         core_d.cnt = 4'h0;
         core_d.oe = 1'b0;
         core_d.pend = 1'b0;
         core_d.op = wtc_pkg::OP_NONE;
      end else if (line.stop) begin
         // programming begins only once the frame is closed
         if (core_q.pend) begin
            core_d.wr_start = 1'b1;
            core_d.wr_slot = core_q.slot;
            core_d.wr_data = core_q.wiper;
            core_d.wr_mask = (core_q.op == wtc_pkg::OP_GSTORE) ?
                             wtc_pkg::ALL_POTS :
                             4'h1 << core_q.pot;
         end
         core_d.pend = 1'b0;
         core_d.state = wtc_pkg::ST_IDLE;
         core_d.oe = 1'b0;
      end else begin
         case (core_q.state)
            wtc_pkg::ST_ADDR,
            wtc_pkg::ST_INSTR: begin
               // collect eight bits, msb first
               if (line.scl_rise && core_q.cnt != wtc_pkg::BYTE_DONE) begin
                  core_d.shift = {core_q.shift[6:0], line.sda_lvl};
                  core_d.cnt = core_q.cnt + 4'h1;
               end else if (line.scl_fall &&
                            core_q.cnt == wtc_pkg::BYTE_DONE) begin
                  core_d.cnt = 4'h0;
                  if (core_q.state == wtc_pkg::ST_ADDR) begin
                     // only our own strap pattern is answered
                     if (core_q.shift == {wtc_pkg::ADDR_NIBBLE,
                                          line.chip_sel}) begin
                        core_d.oe = 1'b1;
                        core_d.state = wtc_pkg::ST_ACK_ADDR;
                     end else begin
                        core_d.state = wtc_pkg::ST_IDLE;
                     end
                  end else begin
                     core_d.op = op_decode(core_q.shift);
                     core_d.slot = core_q.shift[wtc_pkg::SLOT_SEL_LSB +: 2];
                     core_d.pot = core_q.shift[wtc_pkg::POT_SEL_LSB +: 2];
                     if (op_decode(core_q.shift) == wtc_pkg::OP_NONE) begin
                        core_d.state = wtc_pkg::ST_WAIT_STOP;
                     end else begin
                        core_d.oe = 1'b1;
                        core_d.state = wtc_pkg::ST_ACK_INSTR;
                     end
                  end
               end
            end
            wtc_pkg::ST_ACK_ADDR,
            wtc_pkg::ST_ACK_INSTR: begin
               // hold the data line low through the ninth clock
               if (line.scl_rise) begin
                  core_d.cnt = wtc_pkg::ACK_SEEN;
               end else if (line.scl_fall &&
                            core_q.cnt == wtc_pkg::ACK_SEEN) begin
                  core_d.oe = 1'b0;
                  core_d.cnt = 4'h0;
                  if (core_q.state == wtc_pkg::ST_ACK_ADDR) begin
                     core_d.state = wtc_pkg::ST_INSTR;
                  end else begin
                     case (core_q.op)
                        wtc_pkg::OP_STEP: begin
                           core_d.state = wtc_pkg::ST_STEP;
                        end
                        wtc_pkg::OP_RECALL: begin
                           // store answered since the byte ended
                           core_d.wiper[core_q.pot] = nv_rdata_in;
                           core_d.state = wtc_pkg::ST_WAIT_STOP;
                        end
                        wtc_pkg::OP_GSTORE,
                        wtc_pkg::OP_STORE: begin
                           core_d.pend = 1'b1;
                           core_d.state = wtc_pkg::ST_WAIT_STOP;
                        end
                        default: begin
                           core_d.state = wtc_pkg::ST_WAIT_STOP;
                        end
                     endcase
                  end
               end
            end
            wtc_pkg::ST_STEP: begin
               // each clock moves the wiper by the level on data, held at the ends of the range
               if (line.scl_rise) begin
                  core_d.wiper[core_q.pot] =
                     step_wiper(core_q.wiper[core_q.pot],
                                line.sda_lvl);
               end
            end
            wtc_pkg::ST_WAIT_STOP,
            wtc_pkg::ST_IDLE: begin
               // further bytes are neither taken nor acknowledged
               core_d.oe = 1'b0;
            end
            default: begin
               core_d.state = wtc_pkg::ST_IDLE;
               core_d.oe = 1'b0;
            end
         endcase
      end
      // registered run flag so the output comes straight from a flop
      core_d.step = (core_d.state == wtc_pkg::ST_STEP);
   end

   // state register
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         core_q <= '{state: wtc_pkg::ST_IDLE, cnt: 4'h0, shift: 8'h00,
                     op: wtc_pkg::OP_NONE, pot: 2'h0, slot: 2'h0,
                     pend: 1'b0,
                     wiper: {4{wtc_pkg::WIPER_RST}},
                     oe: 1'b0, wr_start: 1'b0, wr_mask: 4'h0,
                     wr_slot: 2'h0, wr_data: 24'h000000, step: 1'b0};
      end else begin
         core_q <= core_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs from flops, data value tied low; the pin is only ever pulled low
   assign sda_out = 1'b0;
   assign sda_oe_out = core_q.oe;
   assign wiper_pos_out = core_q.wiper;
   assign nv_rd_pot_out = core_q.pot;
   assign nv_rd_slot_out = core_q.slot;
   assign nv_wr_start_out = core_q.wr_start;
   assign nv_wr_pot_mask_out = core_q.wr_mask;
   assign nv_wr_slot_out = core_q.wr_slot;
   assign nv_wr_data_out = core_q.wr_data;
   assign step_active_out = core_q.step;
endmodule : wtc_cmd_decode

// >>> verification/wtc_props.sv
module wtc_props (
   input wire logic clk_in, // clock
   input wire logic resetn_in, // reset, active low
   input wire logic scl_in, // bus clock pin
   input wire logic sda_in, // bus data pin
   input wire logic sda_out, // data value
   input wire logic sda_oe_out, // data pull enable
   input wire logic [23:0] wiper_pos_out, // wipers
   input wire logic nv_wr_start_out, // write start
   input wire logic [3:0] nv_wr_pot_mask_out, // write pots
   input wire logic [1:0] nv_wr_slot_out, // write slot
   input wire logic [23:0] nv_wr_data_out, // write data
   input wire logic step_active_out // stepping run
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   logic [3:0] since_stop_q; // cycles since a stop on the pins
   // saturates so a write long after any stop is still caught
   always_ff @(posedge clk_in or negedge resetn_in)
      if (!resetn_in) since_stop_q <= 4'hf;
      else if (scl_in && $rose(sda_in)) since_stop_q <= 4'h0;
      else if (since_stop_q != 4'hf) since_stop_q <= since_stop_q + 4'h1;
   ////////////////////////////////////////////////////////////////////
   sequence oe_up; $rose(sda_oe_out); endsequence
   sequence oe_held; sda_oe_out [*8]; endsequence
   ack_width_a: assert property (oe_up |-> oe_held)
      else $error("ack pulse too short");
   ack_rise_low_a: assert property (oe_up |-> !scl_in)
      else $error("ack rose with clock high");
   ack_fall_low_a: assert property ($fell(sda_oe_out) |-> !scl_in)
      else $error("ack fell with clock high");
   data_zero_a: assert property (sda_oe_out |-> !sda_out)
      else $error("data value not low");
   wr_single_a: assert property (nv_wr_start_out |=> !nv_wr_start_out)
      else $error("write start longer than one cycle");
   wr_after_stop_a: assert property (nv_wr_start_out |->
      since_stop_q < 4'hc)
      else $error("write start without stop");
   job_stable_a: assert property (!nv_wr_start_out |->
      $stable({nv_wr_pot_mask_out, nv_wr_slot_out, nv_wr_data_out}))
      else $error("write job moved between starts");
   mask_shape_a: assert property (nv_wr_start_out |->
      nv_wr_pot_mask_out == 4'hf || $onehot(nv_wr_pot_mask_out))
      else $error("bad write mask");
   step_quiet_a: assert property (step_active_out &&
      $past(step_active_out, 8) |-> !sda_oe_out)
      else $error("ack during stepping");
   step_edge_a: assert property (step_active_out &&
      $changed(wiper_pos_out) |-> scl_in)
      else $error("wiper moved off a clock pulse");
endmodule : wtc_props

// >>> verification/wtc_master.sv
// bus master model; pins change 1 ns after a clock edge
module wtc_master (
   input wire logic clk_in, // system clock
   input wire logic sda_in, // resolved data line
   output logic scl_drv_out, // bus clock
   output logic sda_drv_out // data drive, high releases
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PH = 6; // phase length, above the 4-clock floor
   localparam int NV_WRITE_CYC = 300; // nv_write_time stand-in
   initial begin
      scl_drv_out = 1'b1;
      sda_drv_out = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : wt
   // data falls while clock high
   task automatic bus_start;
      sda_drv_out = 1'b1;
      wt(PH);
      scl_drv_out = 1'b1;
      wt(PH);
      sda_drv_out = 1'b0;
      wt(PH);
      scl_drv_out = 1'b0;
   endtask : bus_start
   // data rises while clock high; the last pulse carries a low bit
   task automatic bus_stop;
      wt(PH);
      sda_drv_out = 1'b0;
      wt(PH);
      scl_drv_out = 1'b1;
      wt(PH);
      sda_drv_out = 1'b1;
      wt(PH);
   endtask : bus_stop
   // late data set lets the device drop its ack first
   task automatic put_bit(input logic b, output logic seen);
      wt(PH);
      sda_drv_out = b;
      wt(PH);
      scl_drv_out = 1'b1;
      wt(8);
      seen = sda_in;
      scl_drv_out = 1'b0;
   endtask : put_bit
   task automatic put_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(v[i], s);
      put_bit(1'b1, s);
      ack = !s;
   endtask : put_byte
   task automatic nv_wait;
      wt(NV_WRITE_CYC);
   endtask : nv_wait
endmodule : wtc_master

// >>> verification/wtc_cmd_decode_bench.sv
module wtc_cmd_decode_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in = 1'b0; // 100 MHz
   logic resetn_in, scl_in, sda_drv, sda_out, sda_oe_out, step_active_out;
   logic [3:0] chip_select_in, nv_wr_pot_mask_out;
   logic [1:0] nv_rd_pot_out, nv_rd_slot_out, nv_wr_slot_out;
   logic [5:0] nv_rdata_in;
   logic nv_wr_start_out;
   logic [23:0] wiper_pos_out, nv_wr_data_out;
   logic [5:0] exp_w [4]; // expected wipers
   int err_count = 0, total_checks = 0, wr_count = 0, cyc = 0;
   wire sda_in = sda_drv & (sda_oe_out ? sda_out : 1'b1); // open drain
   // store model: one odd slot so a wrong read address shows
   assign nv_rdata_in = (nv_rd_pot_out == 2'h1 && nv_rd_slot_out == 2'h2)
      ? 6'h2a : 6'h15;
   always #5 clk_in = ~clk_in;
   // count write pulses away from the edge that launches them
   always @(negedge clk_in) if (nv_wr_start_out) wr_count++;
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_of_test;
      end
   end
   wtc_master master_i (.clk_in, .sda_in, .scl_drv_out(scl_in),
      .sda_drv_out(sda_drv));
   wtc_cmd_decode wtc_cmd_decode_i (.clk_in, .resetn_in, .scl_in, .sda_in,
      .sda_out, .sda_oe_out, .chip_select_in, .wiper_pos_out, .nv_rd_pot_out,
      .nv_rd_slot_out, .nv_rdata_in, .nv_wr_start_out, .nv_wr_pot_mask_out,
      .nv_wr_slot_out, .nv_wr_data_out, .step_active_out);
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [23:0] wvec;
      return {exp_w[3], exp_w[2], exp_w[1], exp_w[0]};
   endfunction : wvec
   task automatic frame(input logic [7:0] ins, input logic ack_i);
      logic a;
      master_i.bus_start;
      master_i.put_byte({wtc_pkg::ADDR_NIBBLE, chip_select_in}, a);
      check({23'h0, a}, 24'h1);
      master_i.put_byte(ins, a);
      check({23'h0, a}, {23'h0, ack_i});
   endtask : frame
   task automatic t_addr;
      logic a;
      master_i.bus_start;
      master_i.put_byte({wtc_pkg::ADDR_NIBBLE, 4'h5}, a);
      check({23'h0, a}, 24'h0);
      master_i.bus_stop;
      $display("address test done");
   endtask : t_addr
   // global store with pot bits set is refused
   task automatic t_bad;
      frame(8'h81, 1'b0);
      master_i.bus_stop;
      check(wiper_pos_out, wvec());
      $display("refusal test done");
   endtask : t_bad
   // down at zero clamps; ends at zero so the stop pulse is harmless
   task automatic t_step;
      logic s;
      logic [6:0] dirs = 7'h38;
      frame(8'h22, 1'b1);
      master_i.wt(6);
      check({23'h0, step_active_out}, 24'h1);
      for (int i = 6; i >= 0; i--) begin
         master_i.put_bit(dirs[i], s);
         check({23'h0, s}, {23'h0, dirs[i]});
         if (dirs[i]) exp_w[2] = exp_w[2] + 6'h01;
         else if (exp_w[2] != wtc_pkg::WIPER_MIN) exp_w[2] = exp_w[2] - 6'h01;
         check(wiper_pos_out, wvec());
      end
      master_i.bus_stop;
      check({23'h0, step_active_out}, 24'h0);
      $display("stepping test done");
   endtask : t_step
   task automatic t_recall;
      frame(8'hd9, 1'b1);
      master_i.bus_stop;
      exp_w[1] = 6'h2a;
      check(wiper_pos_out, wvec());
      $display("recall test done");
   endtask : t_recall
   task automatic t_store(input logic [7:0] ins, input logic [3:0] m);
      int n = wr_count;
      frame(ins, 1'b1);
      master_i.wt(30);
      check({23'h0, wr_count != n}, 24'h0);
      master_i.bus_stop;
      master_i.wt(12);
      check({23'h0, wr_count == n + 1}, 24'h1);
      check({20'h0, nv_wr_pot_mask_out}, {20'h0, m});
      check({22'h0, nv_wr_slot_out}, {22'h0, ins[3:2]});
      check(nv_wr_data_out, wvec());
      master_i.nv_wait;
      $display("store test done");
   endtask : t_store
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      resetn_in = 1'b0;
      chip_select_in = 4'ha;
      for (int i = 0; i < 4; i++) exp_w[i] = wtc_pkg::WIPER_RST;
      repeat (12) @(posedge clk_in);
      #1 resetn_in = 1'b1;
      master_i.wt(4);
      t_addr;
      t_bad;
      t_step;
      t_recall;
      t_store(8'he5, 4'h2);
      t_store(8'h8c, 4'hf);
      end_of_test;
   end
endmodule : wtc_cmd_decode_bench
bind wtc_cmd_decode wtc_props wtc_props_i (.clk_in, .resetn_in, .scl_in,
   .sda_in, .sda_out, .sda_oe_out, .wiper_pos_out, .nv_wr_start_out,
   .nv_wr_pot_mask_out, .nv_wr_slot_out, .nv_wr_data_out, .step_active_out);
